/* dv/mpss_dev_model.sv */
// Purpose: behavioural cellular module power states
// Assumes: hold thresholds in host cycles
// Notes:   detach is instant; deep sleep entered on sleep_in
`default_nettype none
module mpss_dev_model #(
	parameter int unsigned ON_CYC   = 20,
	parameter int unsigned OFF_CYC  = 12,
	parameter int unsigned KILL_CYC = 8
) (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic req_in,
	input  wire logic kill_n_in,
	input  wire logic sleep_in,
	output logic      pwr_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        on_reg;
	logic        deep_reg;
	int unsigned req_run;
	int unsigned kill_run;
	// ==========
	// power states
	assign pwr_out = on_reg && !deep_reg;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			on_reg   <= 1'b0;
			deep_reg <= 1'b0;
			req_run  <= 0;
			kill_run <= 0;
		end else begin
			req_run  <= req_in ? req_run + 1 : 0;
			kill_run <= kill_n_in ? 0 : kill_run + 1;
			if (!req_in && req_run >= ON_CYC && (!on_reg || deep_reg)) begin
				on_reg   <= 1'b1;
				deep_reg <= 1'b0;
			end else if (!on_reg && req_run == 2 * ON_CYC) begin
				// request held far past the on time counts as strapped high
				on_reg   <= 1'b1;
			end else if (pwr_out && (req_run == OFF_CYC || kill_n_in && kill_run >= KILL_CYC)) begin
				on_reg <= 1'b0;
			end else if (sleep_in && pwr_out) begin
				deep_reg <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* dv/mpss_host_sva.sv */
// Purpose: port checker for the power-state sequencer host
// Assumes: one clock, async active-low reset
// Notes:   hold counts come from the bound parameters
`default_nettype none
module mpss_host_chk #(
	parameter int unsigned ON_HOLD_CYC   = 20,
	parameter int unsigned WAKE_HOLD_CYC = 20,
	parameter int unsigned OFF_HOLD_CYC  = 12,
	parameter int unsigned KILL_HOLD_CYC = 8
) (
	input wire logic                 ref_clk_in,
	input wire logic                 resetn_in,
	input wire logic                 cmd_valid_in,
	input wire mpss_pkg::mpss_cmd_t  cmd_in,
	input wire logic                 powered_indicator_in,
	input wire logic                 cmd_ready_out,
	input wire logic                 cmd_done_out,
	input wire logic                 cmd_error_out,
	input wire mpss_pkg::mpss_view_t module_view_out,
	input wire logic                 battery_remove_ok_out,
	input wire logic                 power_wake_req_out,
	input wire logic                 hard_kill_n_out,
	input wire logic                 hard_kill_n_oe_out
);
	import mpss_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned req_run;
	int unsigned kill_run;
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!resetn_in);
	// ==========
	// run lengths of the two pin drives
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			req_run  <= 0;
			kill_run <= 0;
		end else begin
			req_run  <= power_wake_req_out ? req_run + 1 : 0;
			kill_run <= hard_kill_n_oe_out ? kill_run + 1 : 0;
		end
	end
	a_req_hold_len: assert property (
		$fell(power_wake_req_out) |-> req_run inside {ON_HOLD_CYC, WAKE_HOLD_CYC, OFF_HOLD_CYC})
		else $error("request hold length wrong");
	a_req_cause: assert property (
		$rose(power_wake_req_out) |-> $past(cmd_valid_in) && $past(cmd_ready_out))
		else $error("request without accepted command");
	a_kill_len: assert property (
		$fell(hard_kill_n_oe_out) |-> kill_run == KILL_HOLD_CYC)
		else $error("kill pulse length wrong");
	a_kill_level: assert property (
		hard_kill_n_oe_out |-> !hard_kill_n_out)
		else $error("kill driven high");
	a_remove_gate: assert property (
		powered_indicator_in [*6] |-> !battery_remove_ok_out)
		else $error("removal allowed while powered");
	a_view_on: assert property (
		powered_indicator_in [*6] |=> module_view_out == MPSS_VIEW_ON)
		else $error("view not on");
	a_view_off: assert property (
		(!powered_indicator_in) [*6] |=> module_view_out != MPSS_VIEW_ON)
		else $error("view on while unpowered");
	a_none_refused: assert property (
		cmd_valid_in && cmd_ready_out && cmd_in == MPSS_CMD_NONE |-> ##2 cmd_done_out && cmd_error_out)
		else $error("empty command not refused");
endmodule
bind mpss_host mpss_host_chk #(
	.ON_HOLD_CYC(ON_HOLD_CYC), .WAKE_HOLD_CYC(WAKE_HOLD_CYC),
	.OFF_HOLD_CYC(OFF_HOLD_CYC), .KILL_HOLD_CYC(KILL_HOLD_CYC)
) i_mpss_host_chk (
	.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
	.powered_indicator_in(powered_indicator_in), .cmd_ready_out(cmd_ready_out),
	.cmd_done_out(cmd_done_out), .cmd_error_out(cmd_error_out), .module_view_out(module_view_out),
	.battery_remove_ok_out(battery_remove_ok_out), .power_wake_req_out(power_wake_req_out),
	.hard_kill_n_out(hard_kill_n_out), .hard_kill_n_oe_out(hard_kill_n_oe_out)
);
`default_nettype wire

/* dv/tb.sv */
// Purpose: self-checking bench for the power-state sequencer host
// Assumes: hold counts shortened to 20/20/12/8 cycles
// Notes:   results are checked in order of issue through a queue
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; $display("ERROR %0t mismatch", $time); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import mpss_pkg::*;
	logic        ref_clk_in = 1'b0;
	logic        resetn_in = 1'b0;
	mpss_cmd_t   cmd_in = MPSS_CMD_NONE;
	logic        cmd_valid_in = 1'b0;
	logic        battery_ok_in = 1'b1;
	logic        sleep = 1'b0;
	logic        strap = 1'b0;
	logic        pwr, ready, done, err, rm_ok, req, kill_n, kill_oe;
	mpss_view_t  view;
	logic [31:0] lfsr = 32'hDBC3344A;
	logic        exp_q[$];
	int          err_count = 0;
	int          comparisons = 0;
	int          cycles = 0;
	// kill line is pulled up when released
	wire logic   kill_wire = kill_oe ? kill_n : 1'b1;
	mpss_host #(.ON_HOLD_CYC(20), .WAKE_HOLD_CYC(20), .OFF_HOLD_CYC(12), .KILL_HOLD_CYC(8)) i_mpss_host (
		.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .cmd_in(cmd_in), .cmd_valid_in(cmd_valid_in),
		.battery_ok_in(battery_ok_in), .auto_on_strap_in(strap), .powered_indicator_in(pwr),
		.cmd_ready_out(ready), .cmd_done_out(done), .cmd_error_out(err), .module_view_out(view),
		.battery_remove_ok_out(rm_ok), .power_wake_req_out(req), .hard_kill_n_out(kill_n),
		.hard_kill_n_oe_out(kill_oe));
	mpss_dev_model i_mpss_dev_model (.clk_in(ref_clk_in), .rst_n_in(resetn_in), .req_in(req | strap),
		.kill_n_in(kill_wire), .sleep_in(sleep), .pwr_out(pwr));
	// ==========
	// drivers and checks
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic summarize();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic issue(input mpss_cmd_t c, input logic e);
		while (ready !== 1'b1) @(negedge ref_clk_in);
		cmd_in = c;
		cmd_valid_in = 1'b1;
		exp_q.push_back(e);
		@(negedge ref_clk_in);
		lfsr = step(lfsr);
		cmd_valid_in = 1'b0;
		cmd_in = mpss_cmd_t'(lfsr[2:0]);
		@(negedge ref_clk_in);
	endtask
	initial begin
		forever #2 ref_clk_in = ~ref_clk_in;
	end
	// results are read half a cycle after launch, once settled
	always @(negedge ref_clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			summarize();
		end
		if (done === 1'b1) begin
			`CHK(exp_q.size() != 0, 1'b1)
			`CHK(err, exp_q.pop_front())
		end
	end
	initial begin
		repeat (2) @(negedge ref_clk_in);
		resetn_in = 1'b1;
		issue(MPSS_CMD_POWER_OFF, 1'b1);
		battery_ok_in = 1'b0;
		issue(MPSS_CMD_POWER_ON, 1'b1);
		battery_ok_in = 1'b1;
		issue(MPSS_CMD_POWER_ON, 1'b0);
		issue(MPSS_CMD_WAKE, 1'b1);
		issue(MPSS_CMD_HARD_KILL, 1'b0);
		issue(MPSS_CMD_HARD_KILL, 1'b1);
		issue(MPSS_CMD_POWER_ON, 1'b0);
		while (ready !== 1'b1) @(negedge ref_clk_in);
		sleep = 1'b1;
		@(negedge ref_clk_in);
		sleep = 1'b0;
		// let the indicator fall pass the synchroniser
		repeat (8) @(negedge ref_clk_in);
		issue(MPSS_CMD_POWER_OFF, 1'b1);
		issue(MPSS_CMD_HARD_KILL, 1'b1);
		issue(MPSS_CMD_WAKE, 1'b0);
		issue(MPSS_CMD_POWER_OFF, 1'b0);
		issue(MPSS_CMD_NONE, 1'b1);
		while (ready !== 1'b1) @(negedge ref_clk_in);
		`CHK(rm_ok, 1'b1)
		`CHK(view, MPSS_VIEW_DEEP_SLEEP_OR_OFF)
		// second reset with the request line strapped high on the board
		resetn_in = 1'b0;
		strap = 1'b1;
		repeat (2) @(negedge ref_clk_in);
		resetn_in = 1'b1;
		issue(MPSS_CMD_POWER_ON, 1'b1);
		repeat (50) @(negedge ref_clk_in);
		`CHK(view, MPSS_VIEW_ON)
		issue(MPSS_CMD_POWER_OFF, 1'b1);
		summarize();
	end
endmodule
`default_nettype wire

/* rtl/mpss_defines.svh */
// Purpose: timing and width constants for the module power-state sequencer host
// Assumes: 250 MHz host clock
// Notes:   hold times are in milliseconds; cycle counts derive from them
`ifndef MPSS_DEFINES_SVH
`define MPSS_DEFINES_SVH

`define MPSS_CLK_HZ          250000000
`define MPSS_CLK_PER_MS      (`MPSS_CLK_HZ / 1000)
`define MPSS_ON_HOLD_MS      5000
`define MPSS_WAKE_HOLD_MS    5000
`define MPSS_OFF_HOLD_MS     3000
`define MPSS_KILL_HOLD_MS    200
`define MPSS_ON_HOLD_CYC     (`MPSS_ON_HOLD_MS * `MPSS_CLK_PER_MS)
`define MPSS_WAKE_HOLD_CYC   (`MPSS_WAKE_HOLD_MS * `MPSS_CLK_PER_MS)
`define MPSS_OFF_HOLD_CYC    (`MPSS_OFF_HOLD_MS * `MPSS_CLK_PER_MS)
`define MPSS_KILL_HOLD_CYC   (`MPSS_KILL_HOLD_MS * `MPSS_CLK_PER_MS)
`define MPSS_CNT_W           32

`endif

/* rtl/mpss_host.sv */
// Purpose: host-side sequencer that powers a cellular module on, off and out of deep sleep
// Assumes: 250 MHz clock; request pin push-pull; kill pin open-drain
// Notes:   hold times counted in host cycles; counts are parameters to shorten in simulation
`default_nettype none
`include "mpss_defines.svh"
module mpss_host
	import mpss_pkg::*;
#(
	parameter int unsigned ON_HOLD_CYC   = `MPSS_ON_HOLD_CYC,
	parameter int unsigned WAKE_HOLD_CYC = `MPSS_WAKE_HOLD_CYC,
	parameter int unsigned OFF_HOLD_CYC  = `MPSS_OFF_HOLD_CYC,
	parameter int unsigned KILL_HOLD_CYC = `MPSS_KILL_HOLD_CYC
) (
	input  wire logic              ref_clk_in,
	input  wire logic              resetn_in,
	input  wire mpss_pkg::mpss_cmd_t cmd_in,
	input  wire logic              cmd_valid_in,
	input  wire logic              battery_ok_in,
	input  wire logic              auto_on_strap_in,
	input  wire logic              powered_indicator_in,
	output logic                   cmd_ready_out,
	output logic                   cmd_done_out,
	output logic                   cmd_error_out,
	output var mpss_pkg::mpss_view_t module_view_out,
	output logic                   battery_remove_ok_out,
	output logic                   power_wake_req_out,
	output logic                   hard_kill_n_out,
	output logic                   hard_kill_n_oe_out
);
	import mpss_pkg::*;

	// ==========================================================
	// state
	// ==========================================================
	typedef enum logic [2:0] {
		MPSS_ST_IDLE,
		MPSS_ST_HOLD_REQ,
		MPSS_ST_WAIT_MON,
		MPSS_ST_HOLD_KILL,
		MPSS_ST_DONE
	} mpss_seq_t;

	typedef struct packed {
		mpss_seq_t              seq;
		mpss_cmd_t              cmd;
		logic [`MPSS_CNT_W-1:0] cnt;
		logic                   req;
		logic                   kill_oe;
		logic                   ready;
		logic                   done;
		logic                   err;
		mpss_view_t             view;
		logic                   bat_ok;
		logic                   strap;
		logic                   strap_seen;
		logic                   rm_ok;
	} mpss_host_st_t;

	mpss_host_st_t st_reg;
	mpss_host_st_t st_next;

	mpss_sync_if mon_if ();

	mpss_sync u_mon_sync (
		.ref_clk_in (ref_clk_in),
		.resetn_in  (resetn_in),
		.async_in   (powered_indicator_in),
		.sync_out   (mon_if)
	);

	// ==========================================================
	// helpers
	// ==========================================================
	function automatic logic [`MPSS_CNT_W-1:0] hold_of(input mpss_cmd_t c);
		unique case (c)
			MPSS_CMD_POWER_ON:  hold_of = `MPSS_CNT_W'(ON_HOLD_CYC);
			MPSS_CMD_WAKE:      hold_of = `MPSS_CNT_W'(WAKE_HOLD_CYC);
			MPSS_CMD_POWER_OFF: hold_of = `MPSS_CNT_W'(OFF_HOLD_CYC);
			MPSS_CMD_HARD_KILL: hold_of = `MPSS_CNT_W'(KILL_HOLD_CYC);
			default:            hold_of = `MPSS_CNT_W'(1);
		endcase
	endfunction

	// ==========================================================
	// sequencer
	// ==========================================================
	always_comb begin
		st_next      = st_reg;
		st_next.done = 1'b0;
		if (!st_reg.strap_seen) begin
			// strap caught after reset release; tied-high request means module self-starts
			st_next.strap      = auto_on_strap_in;
			st_next.strap_seen = 1'b1;
		end
		// indicator is the only status: low means off or deep sleep
		st_next.view = mon_if.level ? MPSS_VIEW_ON : MPSS_VIEW_DEEP_SLEEP_OR_OFF;
		unique case (st_reg.seq)
			MPSS_ST_IDLE: begin
				st_next.ready = 1'b1;
				if (cmd_valid_in && st_reg.ready) begin
					st_next.ready = 1'b0;
					st_next.err   = 1'b0;
					st_next.cmd   = cmd_in;
					st_next.cnt   = hold_of(cmd_in);
					st_next.seq   = MPSS_ST_DONE;
					unique case (cmd_in)
						MPSS_CMD_POWER_ON, MPSS_CMD_WAKE: begin
							// only from low indicator, good battery, no strap
							if (!mon_if.level && battery_ok_in && !st_reg.strap) begin
								st_next.seq = MPSS_ST_HOLD_REQ;
								st_next.req = 1'b1;
							end else begin
								st_next.err = 1'b1;
							end
						end
						MPSS_CMD_POWER_OFF: begin
							// tied-high strap blocks shutdown too, leaving only the hard kill command
							if (mon_if.level && !st_reg.strap) begin
								st_next.seq = MPSS_ST_HOLD_REQ;
								st_next.req = 1'b1;
							end else begin
								st_next.err = 1'b1;
							end
						end
						MPSS_CMD_HARD_KILL: begin
							// kill acts only while powered; in deep sleep it is refused with an error
							if (mon_if.level) begin
								st_next.seq     = MPSS_ST_HOLD_KILL;
								st_next.kill_oe = 1'b1;
							end else begin
								st_next.err = 1'b1;
							end
						end
						default: begin
							st_next.err = 1'b1;
						end
					endcase
				end
			end
			MPSS_ST_HOLD_REQ: begin
				st_next.cnt = st_reg.cnt - `MPSS_CNT_W'(1);
				if (st_reg.cnt == `MPSS_CNT_W'(1)) begin
					st_next.req = 1'b0;
					st_next.cnt = hold_of(st_reg.cmd);
					st_next.seq = MPSS_ST_WAIT_MON;
				end
			end
			MPSS_ST_HOLD_KILL: begin
				st_next.cnt = st_reg.cnt - `MPSS_CNT_W'(1);
				if (st_reg.cnt == `MPSS_CNT_W'(1)) begin
					st_next.kill_oe = 1'b0;
					st_next.cnt     = hold_of(MPSS_CMD_POWER_ON);
					st_next.seq     = MPSS_ST_WAIT_MON;
				end
			end
			MPSS_ST_WAIT_MON: begin
				// timeout of one more hold interval of the command, or of the power-on hold after a kill; module detach may take seconds
				st_next.cnt = st_reg.cnt - `MPSS_CNT_W'(1);
				if ((st_reg.cmd == MPSS_CMD_POWER_OFF || st_reg.cmd == MPSS_CMD_HARD_KILL)
					? !mon_if.level : mon_if.level) begin
					st_next.seq = MPSS_ST_DONE;
				end else if (st_reg.cnt == `MPSS_CNT_W'(1)) begin
					st_next.err = 1'b1;
					st_next.seq = MPSS_ST_DONE;
				end
			end
			MPSS_ST_DONE: begin
				st_next.done = 1'b1;
				st_next.seq  = MPSS_ST_IDLE;
			end
		endcase
		// registered so the removal permit never glitches between view and state updates
		st_next.rm_ok = (st_next.view == MPSS_VIEW_DEEP_SLEEP_OR_OFF)
			&& (st_next.seq == MPSS_ST_IDLE);
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_reg      <= '0;
			st_reg.seq  <= MPSS_ST_IDLE;
			st_reg.view <= MPSS_VIEW_OFF;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// outputs
	// ==========================================================
	assign cmd_ready_out         = st_reg.ready;
	assign cmd_done_out          = st_reg.done;
	assign cmd_error_out         = st_reg.err;
	assign module_view_out       = st_reg.view;
	// request stays low while off except during a hold, limiting back powering
	assign power_wake_req_out    = st_reg.req;
	assign hard_kill_n_out       = 1'b0;
	assign hard_kill_n_oe_out    = st_reg.kill_oe;
	assign battery_remove_ok_out = st_reg.rm_ok;
endmodule
`default_nettype wire

/* rtl/mpss_pkg.sv */
// Purpose: types for the module power-state sequencer host
// Assumes: nothing
// Notes:   command codes and the host's view of the module
`default_nettype none
package mpss_pkg;
	typedef enum logic [2:0] {
		MPSS_CMD_NONE,
		MPSS_CMD_POWER_ON,
		MPSS_CMD_POWER_OFF,
		MPSS_CMD_WAKE,
		MPSS_CMD_HARD_KILL
	} mpss_cmd_t;

	typedef enum logic [1:0] {
		MPSS_VIEW_OFF,
		MPSS_VIEW_ON,
		MPSS_VIEW_DEEP_SLEEP_OR_OFF
	} mpss_view_t;
endpackage
`default_nettype wire

/* rtl/mpss_sync.sv */
// Purpose: three-flop synchroniser for the module's powered indicator
// Assumes: async pin input
// Notes:   a change counts once stages two and three agree
`default_nettype none
module mpss_sync (
	input  wire logic  ref_clk_in,
	input  wire logic  resetn_in,
	input  wire logic  async_in,
	mpss_sync_if.src   sync_out
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} mpss_sync_st_t;

	mpss_sync_st_t st_reg;
	mpss_sync_st_t st_next;

	always_comb begin
		st_next    = st_reg;
		st_next.s1 = async_in;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		if (st_reg.s2 == st_reg.s3) begin
			st_next.lvl = st_reg.s3;
		end
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync_out.level = st_reg.lvl;
	assign sync_out.rise  = st_next.lvl & ~st_reg.lvl;
	assign sync_out.fall  = ~st_next.lvl & st_reg.lvl;
endmodule
`default_nettype wire

/* rtl/mpss_sync_if.sv */
// Purpose: carries the synchronised monitor level and its edges
// Assumes: one clock
// Notes:   driven by the synchroniser, read by the sequencer
`default_nettype none
interface mpss_sync_if;
	logic level;
	logic rise;
	logic fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire
